// >>> design/i2c_tmo_match.sv
// Master bus timeout and slave own-address match with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module i2c_tmo_match (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [i2c_tmo_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [i2c_tmo_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    output logic start_request_out,
    output logic stop_request_out,
    output logic master_select_out,
    input wire logic cond_done_in,
    output logic irq_out
);
    import i2c_tmo_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                merge[8*i +: 8] = wd[8*i +: 8];
            end
        end
    endfunction

    logic [7:0] timeout_limit_r;
    logic [15:0] own_bus_address_r;
    logic [15:0] bit_period_r;
    logic controller_enable_r, master_select_r, ack_value_select_r;
    logic start_request_r, stop_request_r;
    logic [1:0] status_r, mask_r;
    logic aw_have_r, w_have_r;
    logic [7:0] aw_idx_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    logic [15:0] cyc_cnt_r;
    logic [8:0] bit_cnt_r;
    slv_state_t state_r;
    logic [3:0] sh_cnt_r;
    logic [7:0] shift_r;
    logic ten_bit_r;
    logic sda_oe_n_r;

    logic do_write, ctrl_wr, req_set_evt, scl_fall, scl_rise, bus_start, bus_stop;
    logic tmo_run, tick, expire_evt, match_evt, hdr_ok;
    logic [31:0] ctrl_word, ctrl_new, rd_word;
    logic [31:0] lim_new, own_new, bp_new, mask_new;
    logic [8:0] lim_plus_one;
    logic rd_ok;

    // Write channels accepted in either order; write happens when both held
    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid_out;
    assign ctrl_wr = do_write && (aw_idx_r == IDX_CTRL);
    assign ctrl_word = {27'h0, stop_request_r, start_request_r, ack_value_select_r,
                        master_select_r, controller_enable_r};
    assign ctrl_new = merge(ctrl_word, wdata_r, wstrb_r);
    // Byte-strobed next values of the plain registers
    assign lim_new = merge({24'h0, timeout_limit_r}, wdata_r, wstrb_r);
    assign own_new = merge({16'h0, own_bus_address_r}, wdata_r, wstrb_r);
    assign bp_new = merge({16'h0, bit_period_r}, wdata_r, wstrb_r);
    assign mask_new = merge({30'h0, mask_r}, wdata_r, wstrb_r);

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_idx_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_have_r <= 1'b1;
                aw_idx_r <= {2'b00, s_axi_awaddr_in[ADDR_W-1:2]};
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= (aw_idx_r inside {IDX_CTRL, IDX_STATUS, IDX_MASK, IDX_BIT_PERIOD,
                                    IDX_TIMEOUT_LIMIT, IDX_OWN_ADDR}) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
        end else begin
            s_axi_awready_out <= !aw_have_r && !(s_axi_awvalid_in && s_axi_awready_out) && !do_write;
            s_axi_wready_out <= !w_have_r && !(s_axi_wvalid_in && s_axi_wready_out) && !do_write;
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            timeout_limit_r <= TIMEOUT_LIMIT_RST; // [RULE1]
            own_bus_address_r <= OWN_ADDR_RST; // [RULE8]
            bit_period_r <= BIT_PERIOD_RST;
            mask_r <= 2'b00;
        end else if (do_write) begin
            if (aw_idx_r == IDX_TIMEOUT_LIMIT) begin
                timeout_limit_r <= lim_new[7:0];
            end
            if (aw_idx_r == IDX_OWN_ADDR) begin
                own_bus_address_r <= {6'h00, own_new[9:0]}; // [RULE9]
            end
            if (aw_idx_r == IDX_BIT_PERIOD) begin
                bit_period_r <= bp_new[15:0];
            end
            if (aw_idx_r == IDX_MASK) begin
                mask_r <= mask_new[1:0];
            end
        end
    end

    // Control bits; start and stop requests are mutually exclusive
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            controller_enable_r <= 1'b0;
            master_select_r <= 1'b0;
            ack_value_select_r <= 1'b0;
            start_request_r <= 1'b0;
            stop_request_r <= 1'b0;
        end else begin
            logic en, ms, st, sp;
            en = controller_enable_r;
            ms = master_select_r;
            st = start_request_r;
            sp = stop_request_r;
            if (ctrl_wr) begin
                en = ctrl_new[CTRL_ENABLE];
                ms = ctrl_new[CTRL_MASTER];
                ack_value_select_r <= ctrl_new[CTRL_ACK_VAL];
                if (ctrl_new[CTRL_START] && ctrl_new[CTRL_STOP] && !st && !sp) begin
                    st = 1'b0;
                    sp = 1'b0;
                end else begin
                    st = ctrl_new[CTRL_START] && !sp;
                    sp = ctrl_new[CTRL_STOP] && !st;
                end
            end
            if (cond_done_in) begin
                st = 1'b0;
                sp = 1'b0;
            end
            if (match_evt) begin
                ms = 1'b0; // [RULE11]
            end
            if (expire_evt) begin
                st = 1'b0; // [RULE15]
                sp = 1'b0; // [RULE15]
            end
            if (!ms || !en) begin
                st = 1'b0;
                sp = 1'b0;
            end
            controller_enable_r <= en;
            master_select_r <= ms;
            start_request_r <= st;
            stop_request_r <= sp;
        end
    end

    assign req_set_evt = ctrl_wr && master_select_r && controller_enable_r &&
                         ((ctrl_new[CTRL_START] && !start_request_r && !stop_request_r) ||
                          (ctrl_new[CTRL_STOP] && !stop_request_r && !start_request_r)) &&
                         !(ctrl_new[CTRL_START] && ctrl_new[CTRL_STOP]);

    // Pin synchronisers
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'b111;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'b111;
        end else begin
            {scl_m_r, scl_s_r, scl_d_r} <= {scl_in, scl_m_r, scl_s_r};
            {sda_m_r, sda_s_r, sda_d_r} <= {sda_in, sda_m_r, sda_s_r};
        end
    end

    assign scl_fall = scl_d_r && !scl_s_r;
    assign scl_rise = !scl_d_r && scl_s_r;
    assign bus_start = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
    assign bus_stop = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

    // Bus timeout counter in bit periods
    assign lim_plus_one = {1'b0, timeout_limit_r} + 9'h001; // [RULE3]
    assign tmo_run = master_select_r && controller_enable_r && (timeout_limit_r != 8'h00) && // [RULE2] [RULE5] [RULE7]
                     (start_request_r || stop_request_r || !scl_s_r); // [RULE14]
    assign tick = tmo_run && (cyc_cnt_r >= bit_period_r) && (bit_cnt_r != lim_plus_one);
    assign expire_evt = tick && ((bit_cnt_r + 9'h001) == lim_plus_one); // [RULE6]

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            cyc_cnt_r <= 16'h0000;
            bit_cnt_r <= 9'h000;
        end else if (req_set_evt || scl_fall || !tmo_run) begin
            cyc_cnt_r <= 16'h0000; // [RULE4]
            bit_cnt_r <= 9'h000; // [RULE4]
        end else if (tick) begin
            cyc_cnt_r <= 16'h0000;
            bit_cnt_r <= bit_cnt_r + 9'h001;
        end else if (bit_cnt_r != lim_plus_one) begin
            cyc_cnt_r <= cyc_cnt_r + 16'h0001;
        end
    end

    // Own address receiver, seven and ten bit forms
    assign hdr_ok = (shift_r[7:3] == TEN_BIT_PREFIX) && (shift_r[2:1] == own_bus_address_r[9:8]);
    always_comb begin
        match_evt = 1'b0;
        if (scl_fall && sh_cnt_r == ADDR_BITS && controller_enable_r) begin
            if (state_r == S_ADDR && shift_r[7:3] != TEN_BIT_PREFIX) begin
                match_evt = (shift_r[7:1] == own_bus_address_r[6:0]); // [RULE9]
            end else if (state_r == S_ADDR2) begin
                match_evt = (shift_r == own_bus_address_r[7:0]);
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            state_r <= S_IDLE;
            sh_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ten_bit_r <= 1'b0;
            sda_oe_n_r <= 1'b1;
        end else if (!controller_enable_r || bus_stop) begin
            state_r <= S_IDLE;
            sda_oe_n_r <= 1'b1;
        end else if (bus_start) begin
            state_r <= S_ADDR;
            sh_cnt_r <= 4'h0;
            sda_oe_n_r <= 1'b1;
        end else begin
            unique case (state_r)
                S_IDLE, S_HOLD: begin
                end
                S_ADDR, S_ADDR2: begin
                    if (scl_rise && sh_cnt_r != ADDR_BITS) begin
                        shift_r <= {shift_r[6:0], sda_s_r};
                        sh_cnt_r <= sh_cnt_r + 4'h1;
                    end else if (scl_fall && sh_cnt_r == ADDR_BITS) begin
                        ten_bit_r <= (state_r == S_ADDR) && hdr_ok;
                        if (match_evt || (state_r == S_ADDR && hdr_ok)) begin
                            state_r <= S_ACK;
                            sda_oe_n_r <= ack_value_select_r; // [RULE10]
                        end else begin
                            state_r <= S_IDLE;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n_r <= 1'b1;
                        sh_cnt_r <= 4'h0;
                        state_r <= ten_bit_r ? S_ADDR2 : S_HOLD;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                    sda_oe_n_r <= 1'b1;
                end
            endcase
        end
    end

    // Sticky status; an event in the clearing cycle wins
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            status_r <= 2'b00;
        end else begin
            logic [1:0] clr;
            clr = (do_write && aw_idx_r == IDX_STATUS && wstrb_r[0]) ? wdata_r[1:0] : 2'b00;
            status_r[ST_TIMEOUT] <= expire_evt || (status_r[ST_TIMEOUT] && !clr[ST_TIMEOUT]); // [RULE16]
            status_r[ST_MATCH] <= match_evt || (status_r[ST_MATCH] && !clr[ST_MATCH]); // [RULE11]
        end
    end

    // Read channel
    always_comb begin
        rd_ok = 1'b1;
        unique case ({2'b00, s_axi_araddr_in[ADDR_W-1:2]})
            IDX_CTRL: rd_word = ctrl_word;
            IDX_STATUS: rd_word = {30'h0, status_r};
            IDX_MASK: rd_word = {30'h0, mask_r};
            IDX_BIT_PERIOD: rd_word = {16'h0, bit_period_r};
            IDX_TIMEOUT_LIMIT: rd_word = {24'h0, timeout_limit_r};
            IDX_OWN_ADDR: rd_word = {22'h0, own_bus_address_r[9:0]}; // [RULE13]
            default: begin
                rd_word = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0;
            s_axi_rresp_out <= RESP_OKAY;
        end else begin
            s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_word;
                s_axi_rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // Registered pin and interrupt outputs
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_n_out <= 1'b1;
            start_request_out <= 1'b0;
            stop_request_out <= 1'b0;
            master_select_out <= 1'b0;
        end else begin
            irq_out <= |(status_r & mask_r); // [RULE12] [RULE15]
            sda_out <= 1'b0;
            sda_oe_n_out <= sda_oe_n_r;
            start_request_out <= start_request_r;
            stop_request_out <= stop_request_r;
            master_select_out <= master_select_r;
        end
    end
endmodule // i2c_tmo_match

// >>> design/i2c_tmo_pkg.sv
// Constants for the bus timeout and own-address match block
// What this block does
// [RULE1] Reset clears timeout limit register to zero
// [RULE2] Master mode bounds wait for clock high
// [RULE3] Timeout is limit plus one bit periods
// [RULE4] Start request or clock fall restarts counter
// [RULE5] Zero limit disables timeout, wait forever
// [RULE6] Expiry before clock high sets timeout flag
// [RULE7] Limit has no effect in slave mode
// [RULE8] Reset clears own address register to zero
// [RULE9] Own address in low ten bits, compared
// [RULE10] Match while enabled answers with ack level
// [RULE11] Match sets match flag, clears master select
// [RULE12] Match raises interrupt when enabled
// [RULE13] Upper six address bits read zero
// [RULE14] Start or stop request starts timeout timer
// [RULE15] Expiry clears pending request, raises interrupt
// [RULE16] Timeout flag sticky until software clears
package i2c_tmo_pkg;
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_MASK = 8'h02;
    localparam logic [7:0] IDX_BIT_PERIOD = 8'h03;
    localparam logic [7:0] IDX_TIMEOUT_LIMIT = 8'h0E;
    localparam logic [7:0] IDX_OWN_ADDR = 8'h0F;
    localparam int ADDR_W = 8;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_ACK_VAL = 2;
    localparam int CTRL_START = 3;
    localparam int CTRL_STOP = 4;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_MATCH = 1;
    localparam logic [7:0] TIMEOUT_LIMIT_RST = 8'h00;
    localparam logic [15:0] OWN_ADDR_RST = 16'h0000;
    localparam logic [15:0] BIT_PERIOD_RST = 16'h0064;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    localparam logic [3:0] ADDR_BITS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_ACK = 3'b010,
        S_ADDR2 = 3'b011,
        S_HOLD = 3'b100
    } slv_state_t;
endpackage

// >>> sim/i2c_tmo_match_props.sv
// Port assertions for the bus timeout and own-address match block
`timescale 1ns/1ps
module i2c_tmo_match_props (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic sda_out,
    input wire logic sda_oe_n_out,
    input wire logic start_request_out,
    input wire logic stop_request_out,
    input wire logic master_select_out,
    input wire logic cond_done_in,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    chk_drive_low: assert property (!sda_oe_n_out |-> !sda_out)
        else $error("data line driven high");
    chk_ack_hold: assert property ($fell(sda_oe_n_out) |=> !sda_oe_n_out [*3])
        else $error("ack released early");
    chk_match_master: assert property ($fell(sda_oe_n_out) |-> ##[0:90] !master_select_out)
        else $error("master select kept after match");
    chk_req_excl: assert property (!(start_request_out && stop_request_out))
        else $error("start and stop both pending");
    chk_req_slave: assert property (
        !master_select_out && !$past(master_select_out) |-> !start_request_out && !stop_request_out)
        else $error("request pending in slave mode");
    chk_expiry_irq: assert property (
        $fell(start_request_out) && master_select_out && !$past(cond_done_in) && !$past(cond_done_in, 2)
        |-> ##[0:2] irq_out)
        else $error("no interrupt on expiry");
    chk_done_clears: assert property ($rose(cond_done_in) |-> ##[1:2] !start_request_out && !stop_request_out)
        else $error("request kept after done");
    chk_ar_refuse: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read address taken while data pending");
    chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data changed while stalled");
endmodule // i2c_tmo_match_props
bind i2c_tmo_match i2c_tmo_match_props i2c_tmo_match_props_inst (.*);

// >>> sim/i2c_bus_master_model.sv
// Behavioural bus master driving the clock and data lines
`timescale 1ns/1ps
module i2c_bus_master_model (
    input wire logic bus_sda_in,
    output logic bus_scl_out,
    output logic bus_sda_out
);
    initial begin
        bus_scl_out = 1'h1;
        bus_sda_out = 1'h1;
    end
    task automatic pulses(input int n, input int low_ns, input int high_ns);
        repeat (n) begin
            bus_scl_out = 1'h0;
            #(low_ns);
            bus_scl_out = 1'h1;
            #(high_ns);
        end
    endtask
    // Start, bytes MSB first each with an ack slot, then stop; clock idles high
    task automatic frame(input logic [15:0] w, input int nb, output logic [1:0] acks);
        acks = 2'h3;
        bus_sda_out = 1'h0;
        #100;
        for (int k = 0; k < nb; k++) begin
            for (int i = 8; i >= 0; i--) begin
                bus_scl_out = 1'h0;
                #70;
                bus_sda_out = (i > 0) ? w[8 * (1 - k) + i - 1] : 1'h1;
                #50;
                bus_scl_out = 1'h1;
                #50;
                if (i == 0) acks[k] = bus_sda_in;
                #30;
            end
        end
        bus_scl_out = 1'h0;
        #70;
        bus_sda_out = 1'h0;
        #50;
        bus_scl_out = 1'h1;
        #50;
        bus_sda_out = 1'h1;
        #100;
    endtask
endmodule // i2c_bus_master_model

// >>> sim/tb_top.sv
// Testbench for the bus timeout and own-address match block
`timescale 1ns/1ps
module tb_top;
    import i2c_tmo_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d, rd; logic [1:0] rs;} row_t;
    typedef struct {logic [7:0] c; logic [15:0] own, w; int nb; logic [1:0] ack; logic m;} mt_t;
    logic clk_sys_in = 1'h0, rstn_in = 1'h0, cond_done_in = 1'h0;
    logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
    logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs, ack;
    logic sda_out, sda_oe_n_out, start_request_out, stop_request_out, master_select_out, irq_out, scl_in, m_sda;
    wire sda_in = m_sda & (sda_oe_n_out | sda_out);
    int miscompares = 0, n_compared = 0, cnt;
    row_t rows [5] = '{'{8'h38, 32'hFF, 32'hFF, RESP_OKAY}, '{8'h3C, 32'hFFFF, 32'h3FF, RESP_OKAY},
        '{8'h20, 32'h5A, 32'h0, RESP_SLVERR}, '{8'h0C, 32'h4, 32'h4, RESP_OKAY}, '{8'h08, 32'h3, 32'h3, RESP_OKAY}};
    mt_t mts [5] = '{'{8'h03, 16'h55, 16'hAA00, 1, 2'h2, 1'h1}, '{8'h03, 16'h55, 16'hA800, 1, 2'h3, 1'h0},
        '{8'h07, 16'h55, 16'hAA00, 1, 2'h3, 1'h1}, '{8'h02, 16'h55, 16'hAA00, 1, 2'h3, 1'h0},
        '{8'h03, 16'h2C5, 16'hF4C5, 2, 2'h0, 1'h1}};
    i2c_tmo_match i2c_tmo_match_inst (.*);
    i2c_bus_master_model i2c_bus_master_model_inst (.bus_sda_in(sda_in), .bus_scl_out(scl_in), .bus_sda_out(m_sda));
    always #12.5 clk_sys_in = ~clk_sys_in;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'h1;
        s_axi_wvalid_in <= 1'h1;
        do begin
            @(posedge clk_sys_in);
            n++;
            if (s_axi_bready_in && s_axi_bvalid_out) break;
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
            if (!s_axi_awvalid_in && !s_axi_wvalid_in) s_axi_bready_in <= 1'h1;
        end while (n < 200);
        chk("write answer", 32'h1, s_axi_bready_in && s_axi_bvalid_out);
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'h0;
    endtask
    // Ready lags the answer by a cycle so the read data must stand while stalled
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'h1;
        do begin
            @(posedge clk_sys_in);
            n++;
            if (s_axi_rready_in && s_axi_rvalid_out) break;
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
            else if (!s_axi_arvalid_in) s_axi_rready_in <= 1'h1;
        end while (n < 200);
        chk("read answer", 32'h1, s_axi_rready_in && s_axi_rvalid_out);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'h0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_sys_in);
        rstn_in <= 1'h1;
        foreach (rows[i]) begin
            axi_wr(rows[i].a, rows[i].d, rs);
            chk("bresp", rows[i].rs, rs);
            axi_rd(rows[i].a, rd, rs);
            chk("rdata", rows[i].rd, rd);
            chk("rresp", rows[i].rs, rs);
        end
        @(posedge clk_sys_in);
        rstn_in <= 1'h0;
        repeat (16) @(posedge clk_sys_in);
        rstn_in <= 1'h1;
        axi_rd(8'h38, rd, rs);
        chk("limit after reset", 32'h0, rd);
        axi_rd(8'h3C, rd, rs);
        chk("own address after reset", 32'h0, rd);
        axi_wr(8'h0C, 32'h4, rs);
        axi_wr(8'h08, 32'h3, rs);
        axi_wr(8'h38, 32'h2, rs);
        axi_wr(8'h00, 32'hB, rs);
        // The registered request copy shows one edge after the write returns
        @(posedge clk_sys_in);
        cnt = 0;
        while (start_request_out === 1'h1 && cnt < 60) begin
            @(posedge clk_sys_in);
            cnt++;
        end
        chk("expiry cycles within 11 to 17", 32'h1, cnt >= 11 && cnt <= 17);
        repeat (2) @(posedge clk_sys_in);
        chk("irq on expiry", 32'h1, irq_out);
        axi_wr(8'h00, 32'hB, rs);
        axi_rd(8'h04, rd, rs);
        chk("flag kept on restart", 32'h1, rd);
        repeat (40) @(posedge clk_sys_in);
        axi_wr(8'h04, 32'h1, rs);
        axi_rd(8'h04, rd, rs);
        chk("flag cleared", 32'h0, rd);
        axi_wr(8'h38, 32'h0, rs);
        axi_wr(8'h00, 32'hB, rs);
        repeat (100) @(posedge clk_sys_in);
        chk("request waits", 32'h1, start_request_out);
        axi_rd(8'h04, rd, rs);
        chk("no flag when disabled", 32'h0, rd);
        @(posedge clk_sys_in);
        cond_done_in <= 1'h1;
        @(posedge clk_sys_in);
        cond_done_in <= 1'h0;
        repeat (3) @(posedge clk_sys_in);
        chk("request done", 32'h0, start_request_out);
        axi_wr(8'h38, 32'h2, rs);
        axi_wr(8'h00, 32'h9, rs);
        i2c_bus_master_model_inst.pulses(1, 1000, 100);
        axi_rd(8'h04, rd, rs);
        chk("slave timeout", 32'h0, rd);
        chk("slave request", 32'h0, start_request_out);
        axi_wr(8'h00, 32'h3, rs);
        i2c_bus_master_model_inst.pulses(6, 150, 150);
        axi_rd(8'h04, rd, rs);
        chk("falls restart count", 32'h0, rd);
        i2c_bus_master_model_inst.pulses(1, 700, 100);
        axi_rd(8'h04, rd, rs);
        chk("clock held low", 32'h1, rd);
        axi_wr(8'h04, 32'h1, rs);
        axi_wr(8'h00, 32'h13, rs);
        @(posedge clk_sys_in);
        chk("stop pending", 32'h1, stop_request_out);
        repeat (30) @(posedge clk_sys_in);
        chk("stop cleared on expiry", 32'h0, stop_request_out);
        axi_rd(8'h04, rd, rs);
        chk("stop timeout flag", 32'h1, rd);
        foreach (mts[i]) begin
            axi_wr(8'h04, 32'h3, rs);
            axi_wr(8'h3C, mts[i].own, rs);
            axi_wr(8'h00, mts[i].c, rs);
            i2c_bus_master_model_inst.frame(mts[i].w, mts[i].nb, ack);
            axi_rd(8'h04, rd, rs);
            chk("match flag", mts[i].m, rd[1]);
            chk("ack", mts[i].ack, ack);
            chk("master select", !mts[i].m, master_select_out);
            chk("irq on match", mts[i].m, irq_out);
        end
        axi_wr(8'h08, 32'h0, rs);
        repeat (2) @(posedge clk_sys_in);
        chk("irq masked", 32'h0, irq_out);
        axi_wr(8'h08, 32'h3, rs);
        axi_wr(8'h04, 32'h2, rs);
        repeat (2) @(posedge clk_sys_in);
        chk("irq cleared", 32'h0, irq_out);
        give_verdict();
    end
endmodule // tb_top
